// >>> hw/bus_xcvr_defines.svh
// Constants of the registered bus transceiver: register offsets, field
// positions and reset values.
// Assumes inclusion by bare name from design files under hw/.
`ifndef BUS_XCVR_DEFINES_SVH
`define BUS_XCVR_DEFINES_SVH

// ==========================================================================
// Register map, byte addresses on the APB word grid.
`define XCVR_CTRL_OFS        12'h000
`define XCVR_STORE_OFS       12'h004
`define XCVR_LIVE_OFS        12'h008

// ==========================================================================
// Control register fields.
`define XCVR_CTRL_OE_N_BIT   0
`define XCVR_CTRL_DIR_BIT    1
`define XCVR_CTRL_AB_SEL_BIT 2
`define XCVR_CTRL_BA_SEL_BIT 3
`define XCVR_CTRL_W          4
`define XCVR_CTRL_RST        4'h1

// ==========================================================================
// Port width and field positions of the store and live registers.
`define XCVR_DATA_W          8
`define XCVR_LO_LSB          0
`define XCVR_HI_LSB          8

`endif

// >>> hw/bus_xcvr_pkg.sv
// Types shared by the registered bus transceiver design files.
// Assumes nothing of its surroundings; holds no constants of the map.
package bus_xcvr_pkg;

  // ========================================================================
  // Which port the transceiver drives this cycle.
  typedef enum logic [1:0]
  {
    DRV_NONE = 2'b00,
    DRV_A    = 2'b01,
    DRV_B    = 2'b10
  } drive_e;

endpackage

// >>> hw/pin_sync.sv
// Two-stage synchroniser with rising-edge detect for a group of pins.
// Assumes pins are asynchronous to i_clk_sys and change slower than it.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);

  // ========================================================================
  // Per-bit chain: the first stage feeds only the second stage.
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      logic prev_r;

      // Edge detect looks at the second and third stage only.
      always_ff @(posedge i_clk_sys)
      begin
        if (!i_resetn)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end
        else
        begin
          meta_r <= i_pin[g];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end

      assign o_level[g] = sync_r;
      assign o_rise[g]  = sync_r & ~prev_r;
    end
  endgenerate

endmodule

`default_nettype wire

// >>> hw/registered_bus_transceiver.sv
// Registered eight-bit bus transceiver between two parallel buses A and B,
// with its control bits reached over an APB slave.
// Assumes all port pins and capture clocks are asynchronous to i_clk_sys
// and that the bench resolves each pin from the output enables.
//
// How it works
// (R1) Rising capture clock loads its register.
// (R2) Capture ignores enable, direction and selects.
// (R3) Output enable off: no port driven.
// (R4) Undriven port keeps being sampled and stored.
// (R5) Direction low drives A, high drives B.
// (R6) Driving A: select picks live B or register.
// (R7) Driving B: select picks live A or register.
// (R8) Never drive both ports together.
// (R9) Undriven input may load either or both registers.
// (R10) Port drive depends only on enable and direction.
// (R11) Eight-bit ports and registers, per-port tri-state enable.
// (R12) Outside keeps capture clock quiet while presenting.
`timescale 1ns/1ps
`default_nettype none
`include "bus_xcvr_defines.svh"

module registered_bus_transceiver #(
  parameter int DATA_W = `XCVR_DATA_W,
  parameter int ADDR_W = 12
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // APB slave.
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Port A pins.
  input  wire logic [DATA_W-1:0] i_a_data,
  output logic      [DATA_W-1:0] o_a_data,
  output logic                   o_a_oe,
  // Port B pins.
  input  wire logic [DATA_W-1:0] i_b_data,
  output logic      [DATA_W-1:0] o_b_data,
  output logic                   o_b_oe,
  // Capture clocks, sampled as ordinary pins.
  input  wire logic              i_a_to_b_capture_clock,
  input  wire logic              i_b_to_a_capture_clock
);

  localparam int SYNC_W = 2 * DATA_W + 2;

  // ========================================================================
  // Pin synchronisers
  // ========================================================================
  // All pins pass two flops together so data and clock edges stay aligned.
  logic [SYNC_W-1:0] sync_level;
  logic [SYNC_W-1:0] sync_rise;

  pin_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_pin     ({i_b_to_a_capture_clock, i_a_to_b_capture_clock,
                 i_b_data, i_a_data}),
    .o_level   (sync_level),
    .o_rise    (sync_rise)
  );

  // Named views of the synchronised pins.
  wire logic [DATA_W-1:0] a_live    = sync_level[DATA_W-1:0];
  wire logic [DATA_W-1:0] b_live    = sync_level[2*DATA_W-1:DATA_W];
  wire logic              ab_edge   = sync_rise[2*DATA_W];
  wire logic              ba_edge   = sync_rise[2*DATA_W+1];

  // ========================================================================
  // Control register
  // ========================================================================
  logic [`XCVR_CTRL_W-1:0] ctrl_r;
  logic [`XCVR_CTRL_W-1:0] ctrl_nxt;

  wire logic oe_n    = ctrl_r[`XCVR_CTRL_OE_N_BIT];
  wire logic dir     = ctrl_r[`XCVR_CTRL_DIR_BIT];
  wire logic a_to_b_source_select = ctrl_r[`XCVR_CTRL_AB_SEL_BIT];
  wire logic b_to_a_source_select = ctrl_r[`XCVR_CTRL_BA_SEL_BIT];

  // ========================================================================
  // APB decode
  // ========================================================================
  // Setup is answered one edge later, so the access phase never waits.
  wire logic apb_setup  = i_psel & ~i_penable;
  wire logic apb_commit = i_psel & i_penable & o_pready;
  wire logic hit_ctrl   = (i_paddr == `XCVR_CTRL_OFS);
  wire logic hit_store  = (i_paddr == `XCVR_STORE_OFS);
  wire logic hit_live   = (i_paddr == `XCVR_LIVE_OFS);
  wire logic hit_any    = hit_ctrl | hit_store | hit_live;
  // Store and live words are read only; a write there is an error.
  wire logic bad_access = ~hit_any | (i_pwrite & ~hit_ctrl);
  wire logic ctrl_wr    = apb_commit & i_pwrite & hit_ctrl & i_pstrb[0];
  // Only the low bits of the word carry control; the rest is ignored so a
  // wider software write stays harmless.
  wire logic [`XCVR_CTRL_W-1:0] wr_ctrl_bits = i_pwdata[`XCVR_CTRL_W-1:0];

  assign ctrl_nxt = ctrl_wr ? wr_ctrl_bits : ctrl_r;

  // ========================================================================
  // Capture registers
  // ========================================================================
  logic [DATA_W-1:0] ab_store_r;
  logic [DATA_W-1:0] ba_store_r;
  logic [DATA_W-1:0] ab_store_nxt;
  logic [DATA_W-1:0] ba_store_nxt;

  // Loading looks at the capture edge alone, never at the output setup;
  // so the undriven port, or both ports in isolation, can be stored.
  assign ab_store_nxt = ab_edge ? a_live : ab_store_r; // R1 R2 R4 R9
  assign ba_store_nxt = ba_edge ? b_live : ba_store_r; // R1 R2 R4 R9

  // Read data mux, taken in the setup cycle.
  wire logic [31:0] store_word = {{(32 - 2 * DATA_W){1'b0}}, ba_store_r, ab_store_r};
  wire logic [31:0] live_word  = {{(32 - 2 * DATA_W){1'b0}}, b_live, a_live};
  wire logic [31:0] ctrl_word  = {{(32 - `XCVR_CTRL_W){1'b0}}, ctrl_r};
  wire logic [31:0] rd_word    = hit_ctrl  ? ctrl_word :
                                 hit_store ? store_word :
                                 hit_live  ? live_word : 32'h0000_0000;

  // ========================================================================
  // Drive selection
  // ========================================================================
  // Which port is an output follows enable and direction only; a capture
  // edge has no say in it.
  bus_xcvr_pkg::drive_e drive_sel;
  assign drive_sel = oe_n ? bus_xcvr_pkg::DRV_NONE :   // R3 R10
                     dir  ? bus_xcvr_pkg::DRV_B :      // R5
                            bus_xcvr_pkg::DRV_A;       // R5

  // Source for each port: live value from the far port or stored word.
  // The register path lags the live path by one edge after a capture; the
  // outside keeps the capture clock quiet while presenting stored data.
  wire logic [DATA_W-1:0] a_src = b_to_a_source_select ? ba_store_r : b_live; // R6 R12
  wire logic [DATA_W-1:0] b_src = a_to_b_source_select ? ab_store_r : a_live; // R7 R12

  logic a_oe_nxt;
  logic b_oe_nxt;

  // One-hot enables from the drive state; at most one port at a time.
  always_comb
  begin
    a_oe_nxt = 1'b0;
    b_oe_nxt = 1'b0;
    case (drive_sel)
      bus_xcvr_pkg::DRV_A:
      begin
        a_oe_nxt = 1'b1; // R5 R8
      end
      bus_xcvr_pkg::DRV_B:
      begin
        b_oe_nxt = 1'b1; // R5 R8
      end
      default:
      begin
        a_oe_nxt = 1'b0; // R3
        b_oe_nxt = 1'b0; // R3
      end
    endcase
  end

  // ========================================================================
  // Register processes
  // ========================================================================
  // Control and capture state.
  // Store registers clear at reset so reads are defined; the outside must
  // still load them before it trusts a stored word.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      ctrl_r     <= `XCVR_CTRL_RST;
      ab_store_r <= '0;
      ba_store_r <= '0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      ab_store_r <= ab_store_nxt; // R1
      ba_store_r <= ba_store_nxt; // R1
    end
  end

  // APB answer flops.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
    else
    begin
      o_pready  <= apb_setup;
      o_pslverr <= apb_setup & bad_access;
      o_prdata  <= (apb_setup & ~i_pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Pin drivers; the unused data lines park at zero.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      o_a_oe   <= 1'b0;
      o_b_oe   <= 1'b0;
      o_a_data <= '0;
      o_b_data <= '0;
    end
    else
    begin
      o_a_oe   <= a_oe_nxt;                        // R11
      o_b_oe   <= b_oe_nxt;                        // R11
      o_a_data <= a_oe_nxt ? a_src : '0;           // R6
      o_b_data <= b_oe_nxt ? b_src : '0;           // R7
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  // Steps of an APB transfer as this slave sees them, and the two drive states.
  sequence s_apb_setup;
    i_psel && !i_penable;
  endsequence

  sequence s_apb_answer;
    o_pready;
  endsequence

  sequence s_drive_a;
    !oe_n && !dir;
  endsequence

  sequence s_drive_b;
    !oe_n && dir;
  endsequence

  a_no_dual_drive: assert property (!(o_a_oe && o_b_oe)) // R8
    else $error("Both ports driven at once.");

  a_off_no_drive: assert property (oe_n |=> !o_a_oe && !o_b_oe) // R3
    else $error("A port is driven while the output enable is off.");

  a_dir_a_drive: assert property (s_drive_a |=> o_a_oe && !o_b_oe) // R5
    else $error("Direction low did not drive port A alone.");

  a_dir_b_drive: assert property (s_drive_b |=> o_b_oe && !o_a_oe) // R5
    else $error("Direction high did not drive port B alone.");

  a_ab_capture: assert property (ab_edge |=> ab_store_r == $past(a_live)) // R1
    else $error("A-to-B register missed its capture.");

  a_ba_capture: assert property (ba_edge |=> ba_store_r == $past(b_live)) // R1
    else $error("B-to-A register missed its capture.");

  a_store_hold: assert property (!ab_edge && !ba_edge |=> $stable(ab_store_r)
    && $stable(ba_store_r)) // R2
    else $error("A capture register changed without its clock edge.");

  a_capture_isolated: assert property (oe_n && ab_edge && ba_edge
    |=> ab_store_r == $past(a_live) && ba_store_r == $past(b_live)) // R4
    else $error("Capture failed while both ports were undriven.");

  a_a_from_store: assert property (s_drive_a and b_to_a_source_select
    |=> o_a_data == $past(ba_store_r)) // R6
    else $error("Port A did not show the B-to-A register.");

  a_a_from_live: assert property (s_drive_a and !b_to_a_source_select
    |=> o_a_data == $past(b_live)) // R6
    else $error("Port A did not show live B data.");

  a_b_from_store: assert property (s_drive_b and a_to_b_source_select
    |=> o_b_data == $past(ab_store_r)) // R7
    else $error("Port B did not show the A-to-B register.");

  a_b_from_live: assert property (s_drive_b and !a_to_b_source_select
    |=> o_b_data == $past(a_live)) // R7
    else $error("Port B did not show live A data.");

  a_apb_one_wait: assert property (s_apb_setup |=> s_apb_answer ##1 !o_pready)
    else $error("APB answer not given in the access cycle.");

  // Error and read data stand only in the access cycle, so a master that
  // samples them late sees zero rather than a stale word.
  a_err_in_access: assert property (o_pslverr |-> o_pready)
    else $error("Slave error raised outside the access cycle.");

  a_rdata_park: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("Read data not parked at zero between transfers.");

  a_err_unmapped: assert property (i_psel && !i_penable && !hit_any |=> o_pslverr)
    else $error("Unmapped address answered without an error.");

  // Read data carries the word that stood at the setup edge.
  a_rd_ctrl_word: assert property (i_psel && !i_penable && !i_pwrite && hit_ctrl
    |=> o_prdata[`XCVR_CTRL_W-1:0] == $past(ctrl_r))
    else $error("Control read returned the wrong word.");

  a_rd_store_word: assert property (i_psel && !i_penable && !i_pwrite && hit_store // R1
    |=> o_prdata[DATA_W-1:0] == $past(ab_store_r)
    && o_prdata[2*DATA_W-1:DATA_W] == $past(ba_store_r))
    else $error("Store read returned the wrong registers.");

  // A taken control write lands; a refused one leaves the word alone.
  a_ctrl_write: assert property (ctrl_wr |=> ctrl_r == $past(wr_ctrl_bits))
    else $error("Control write did not land.");

  a_ctrl_refused: assert property (apb_commit && i_pwrite && !ctrl_wr |=> $stable(ctrl_r))
    else $error("Control word changed on a refused write.");

  // Each register keeps its word until its own capture edge, whatever the
  // other register or the output setup is doing.
  a_ab_store_hold: assert property (!ab_edge |=> $stable(ab_store_r)) // R2
    else $error("A-to-B register changed without its capture edge.");

  a_ba_store_hold: assert property (!ba_edge |=> $stable(ba_store_r)) // R2
    else $error("B-to-A register changed without its capture edge.");

  // A capture edge never turns a port around while the control word stands.
  a_edge_no_turn: assert property ($stable(ctrl_r) && (ab_edge || ba_edge) // R10
    |=> $stable(o_a_oe) && $stable(o_b_oe))
    else $error("A capture edge changed which port is driven.");

  // Undriven data lines park at zero, so a released bus sees no stale word.
  a_a_idle_zero: assert property (!o_a_oe |-> o_a_data == '0) // R11
    else $error("Port A data not parked while undriven.");

  a_b_idle_zero: assert property (!o_b_oe |-> o_b_data == '0) // R11
    else $error("Port B data not parked while undriven.");

endmodule

`default_nettype wire

// >>> tb/far_bus_model.sv
// Behavioural model of the logic on buses A and B and of both capture clocks.
// Assumes the bench calls its tasks from a process synchronised to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none

module far_bus_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_a_oe,
  input  wire logic [7:0] i_a_out,
  input  wire logic       i_b_oe,
  input  wire logic [7:0] i_b_out,
  output logic      [7:0] o_a_pin,
  output logic      [7:0] o_b_pin,
  output logic            o_cap_ab,
  output logic            o_cap_ba
);
  // ==========================================================================
  // Bus resolution
  // The far drivers step back whenever the device drives a bus, so a wire
  // never carries two drivers and the device's own value loops back.
  logic [7:0] a_far;
  logic [7:0] b_far;

  assign o_a_pin = i_a_oe ? i_a_out : a_far;
  assign o_b_pin = i_b_oe ? i_b_out : b_far;

  initial
  begin
    a_far    = 8'h00;
    b_far    = 8'h00;
    o_cap_ab = 1'b0;
    o_cap_ba = 1'b0;
  end

  // ==========================================================================
  // Stimulus tasks
  // New far values, then enough cycles for the pin synchroniser to settle.
  task automatic set_bus(input logic [7:0] a, input logic [7:0] b);
    a_far <= a;
    b_far <= b;
    repeat (6) @(posedge i_clk_sys);
  endtask

  // Capture clocks stay low outside a pulse, so a presented stored value
  // holds still; the high phase lasts four cycles and the low six, above the two-cycle minimum.
  task automatic pulse(input logic ab, input logic ba);
    o_cap_ab <= ab;
    o_cap_ba <= ba;
    repeat (4) @(posedge i_clk_sys);
    o_cap_ab <= 1'b0;
    o_cap_ba <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the registered bus transceiver over APB.
// Assumes the far_bus_model resolves both buses from the output enables.
`timescale 1ns/1ps
`default_nettype none
`include "bus_xcvr_defines.svh"

module testbench;
  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  a_out;
  logic [7:0]  b_out;
  logic [7:0]  a_pin;
  logic [7:0]  b_pin;
  logic        a_oe;
  logic        b_oe;
  logic        cap_ab;
  logic        cap_ba;
  logic [31:0] rdat;
  logic        rerr;
  int          err_total = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  registered_bus_transceiver u_registered_bus_transceiver (
    .i_clk_sys(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_a_data(a_pin), .o_a_data(a_out), .o_a_oe(a_oe),
    .i_b_data(b_pin), .o_b_data(b_out), .o_b_oe(b_oe),
    .i_a_to_b_capture_clock(cap_ab), .i_b_to_a_capture_clock(cap_ba));

  far_bus_model u_far_bus_model (
    .i_clk_sys(clk), .i_a_oe(a_oe), .i_a_out(a_out), .i_b_oe(b_oe),
    .i_b_out(b_out), .o_a_pin(a_pin), .o_b_pin(b_pin),
    .o_cap_ab(cap_ab), .o_cap_ba(cap_ba));

  // ==========================================================================
  // Clock, timeout and the closing report
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      err_total++;
      stop_test();
    end
  end

  // Both buses driven at once would short the wires, so watch every cycle out of reset.
  always @(posedge clk)
    if (resetn)
      check(32'({a_oe, b_oe}) & 32'h0000_0003 & {30'h0, 2'b11} & 32'h0000_0000 |
            32'(a_oe & b_oe), 32'h0000_0000);

  // ==========================================================================
  // APB master: request held until pready is sampled high with penable.
  task automatic xfer(input logic wr, input logic [11:0] ad,
                      input logic [31:0] wd, input logic [3:0] st);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Control write, then time for the outputs and pin loop-back to settle.
  task automatic cfg(input logic [3:0] c);
    xfer(1'b1, `XCVR_CTRL_OFS, {28'h000_0000, c}, 4'hF);
    repeat (6) @(posedge clk);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    resetn  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    xfer(1'b0, `XCVR_CTRL_OFS, 32'h0000_0000, 4'h0);
    check(rdat, 32'h0000_0001);
    check(32'({a_oe, b_oe}), 32'h0000_0000);
    // Isolation: each bus loads its own register.
    u_far_bus_model.set_bus(8'h5A, 8'hC3);
    u_far_bus_model.pulse(1'b1, 1'b1);
    xfer(1'b0, `XCVR_STORE_OFS, 32'h0000_0000, 4'h0);
    check(rdat, 32'h0000_C35A);
    xfer(1'b0, `XCVR_LIVE_OFS, 32'h0000_0000, 4'h0);
    check(rdat, 32'h0000_C35A);
    // Drive A from live B, then store the B value in both registers.
    cfg(4'h0);
    check(32'({a_oe, b_oe}), 32'h0000_0002);
    check(32'(a_out), 32'h0000_00C3);
    u_far_bus_model.set_bus(8'h00, 8'h77);
    check(32'(a_out), 32'h0000_0077);
    u_far_bus_model.pulse(1'b1, 1'b1);
    xfer(1'b0, `XCVR_STORE_OFS, 32'h0000_0000, 4'h0);
    check(rdat, 32'h0000_7777);
    check(32'({a_oe, b_oe}), 32'h0000_0002);
    u_far_bus_model.set_bus(8'h00, 8'h11);
    cfg(4'h8);
    check(32'(a_out), 32'h0000_0077);
    // Drive B, live A then the stored A-to-B value.
    u_far_bus_model.set_bus(8'h96, 8'h11);
    cfg(4'h2);
    check(32'({a_oe, b_oe}), 32'h0000_0001);
    check(32'(b_out), 32'h0000_0096);
    cfg(4'h6);
    check(32'(b_out), 32'h0000_0077);
    cfg(4'h7);
    check(32'({a_oe, b_oe}), 32'h0000_0000);
    check(32'(b_out), 32'h0000_0000);
    // Refused accesses leave the control word alone.
    xfer(1'b1, `XCVR_STORE_OFS, 32'h0000_FFFF, 4'hF);
    check(32'(rerr), 32'h0000_0001);
    xfer(1'b0, 12'h00C, 32'h0000_0000, 4'h0);
    check(32'(rerr), 32'h0000_0001);
    xfer(1'b1, `XCVR_CTRL_OFS, 32'h0000_0000, 4'h0);
    check(32'(rerr), 32'h0000_0000);
    xfer(1'b0, `XCVR_CTRL_OFS, 32'h0000_0000, 4'h0);
    check(rdat, 32'h0000_0007);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
